// ### astx_baud_gen.sv
// baud generator: one tick every lim+1 clocks, lim being the divisor or, in 8 bit mode, its low byte
// assumes run is held low while idle; back-to-back frames keep it high and still start a fresh period at the tick
`timescale 1ns/100ps
module astx_baud_gen (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // divisor and tick
  astx_baud_if.gen  bif
);
  logic [15:0] cnt_r;
  logic [15:0] lim;

  // 8 bit mode ignores the upper divisor byte
  assign lim = bif.wide ? bif.divisor : {8'h00, bif.divisor[7:0]};
  // compare with >= so a divisor cut below the running count cannot wrap the counter
  assign bif.tick = bif.run && (cnt_r >= lim);

  // counter restarts on every tick and while stopped
  always_ff @(posedge core_clk) begin
    if (rst || !bif.run || bif.tick) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // after a tick the next one is a full period away unless lim (the divisor, or its low byte in 8 bit mode) is zero
  property p_tick_gap;
    @(posedge core_clk) disable iff (rst)
      bif.tick |=> !bif.tick || (lim == 16'h0000);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("baud tick repeated early");
endmodule // astx_baud_gen

// ### astx_baud_if.sv
// interface carrying the baud tick and its divisor between top and generator
// assumes one clock domain
`timescale 1ns/100ps
interface astx_baud_if;
  logic [15:0] divisor;
  logic        wide;
  logic        run;
  logic        tick;
  modport gen (input divisor, input wide, input run, output tick);
  modport use_side (output divisor, output wide, output run, input tick);
endinterface

// ### astx_pkg.sv
// package for the asynchronous serial transmitter: register map, fields, resets, counts
// assumes a plain register port with read data one cycle after the read strobe
package astx_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [3:0] ASTX_OFS_DATA  = 4'h0;
  localparam logic [3:0] ASTX_OFS_CTRL  = 4'h4;
  localparam logic [3:0] ASTX_OFS_BAUD  = 4'h8;
  localparam logic [3:0] ASTX_OFS_STAT  = 4'hc;
  // control field positions
  localparam int ASTX_CTL_TRANSMIT_ENABLE_BIT  = 0;
  localparam int ASTX_CTL_SYNC  = 1;
  localparam int ASTX_CTL_SERIAL_PORT_ENABLE  = 2;
  localparam int ASTX_CTL_POL   = 3;
  localparam int ASTX_CTL_NINE  = 4;
  localparam int ASTX_CTL_BIT9  = 5;
  localparam int ASTX_CTL_B16   = 6;
  localparam int ASTX_CTL_IE    = 7;
  // status field positions
  localparam int ASTX_ST_EMPTY  = 0;
  localparam int ASTX_ST_SHEMP  = 1;
  localparam int ASTX_ST_IRQ    = 2;
  // reset values
  localparam logic [7:0]  ASTX_CTRL_RST = 8'h00;
  localparam logic [15:0] ASTX_BAUD_RST = 16'h0000;
  // frame: start + up to nine data + one stop
  localparam logic [3:0]  ASTX_BITS_8   = 4'ha;
  localparam logic [3:0]  ASTX_BITS_9   = 4'hb;
  // cycles from a buffer write until the empty flag shows it
  localparam int ASTX_FLAG_LAT = 2;
endpackage

// ### astx_rx_model.sv
// remote receiver model: decodes the frames seen on the transmit pin
// assumes the bench gives the bit time in core_clk cycles and the format
`timescale 1ns/100ps
module astx_rx_model (
  // clock and line
  input  wire logic        core_clk,
  input  wire logic        line,
  // format
  input  wire logic        inv,
  input  wire logic        nine,
  input  wire logic [16:0] bit_cyc,
  // decoded characters
  output logic      [8:0]  rx_word,
  output logic             rx_ok,
  output int               rx_cnt,
  output int               rx_gap
);
  logic lvl;
  int   cyc = 0;
  int   t0;
  int   s;
  ////////////////////////////////////////////////////////////
  // undo the polarity so that a mark reads as one
  assign lvl = line ^ inv;
  // sample on the falling edge, clear of the pin's own update
  always @(negedge core_clk) cyc <= cyc + 1;
  // centre sampling: a period off by one cycle drifts out within a frame
  initial begin
    rx_cnt = 0;
    rx_gap = 0;
    rx_ok = 1'b0;
    rx_word = 9'h000;
    t0 = 0;
    forever begin
      @(negedge core_clk);
      if (lvl === 1'b0) begin
        s = cyc;
        repeat (bit_cyc / 2) @(negedge core_clk);
        // a short glitch is dropped, as a real receiver would
        if (lvl === 1'b0) begin
          rx_gap = s - t0;
          t0 = s;
          rx_word = 9'h000;
          for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_cyc) @(negedge core_clk);
            rx_word[i] = lvl;
          end
          repeat (bit_cyc) @(negedge core_clk);
          rx_ok = (lvl === 1'b1);
          rx_cnt++;
        end
      end
    end
  end
endmodule // astx_rx_model

// ### astx_top.sv
// asynchronous serial transmitter with one-deep holding buffer
// assumes a single clock and a master that never waits
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module astx_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // transmit pin
  output logic             transmit_pin_o,
  output logic             transmit_pin_oe,
  // interrupt request level
  output logic             tx_irq
);
  typedef enum logic [0:0] {ASTX_IDLE, ASTX_SEND} astx_state_t;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ctrl_r;
  logic [15:0] baud_r;
  logic [8:0]  tx_holding_buffer_r;
  logic        hold_full_r;
  logic [9:0]  tx_shift_register_r;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  frame_len_r;
  astx_state_t state_r;
  logic [1:0]  wr_dly_r;
  logic        flag_r;
  logic        transmit_enable_bit_d_r;

  // control decode
  logic transmit_enable_bit, sync_sel, serial_port_enable, output_polarity_invert;
  logic nine_bit_enable, ninth_data_bit, wide_div, buffer_empty_irq_enable;
  logic active, wr_data, wr_ctrl, wr_baud, load, bit_done, frame_done, line_level;
  logic shift_empty_status;
  astx_baud_if bif ();

  assign transmit_enable_bit     = ctrl_r[astx_pkg::ASTX_CTL_TRANSMIT_ENABLE_BIT];
  assign sync_sel                = ctrl_r[astx_pkg::ASTX_CTL_SYNC];
  assign serial_port_enable      = ctrl_r[astx_pkg::ASTX_CTL_SERIAL_PORT_ENABLE];
  assign output_polarity_invert  = ctrl_r[astx_pkg::ASTX_CTL_POL];
  assign nine_bit_enable         = ctrl_r[astx_pkg::ASTX_CTL_NINE];
  assign ninth_data_bit          = ctrl_r[astx_pkg::ASTX_CTL_BIT9];
  assign wide_div                = ctrl_r[astx_pkg::ASTX_CTL_B16];
  assign buffer_empty_irq_enable = ctrl_r[astx_pkg::ASTX_CTL_IE];

  ////////////////////////////////////////////////////////////////////////
  // bus decode and baud generator hookup
  assign active  = transmit_enable_bit && !sync_sel && serial_port_enable;
  assign wr_data = wr && (addr == astx_pkg::ASTX_OFS_DATA);
  assign wr_ctrl = wr && (addr == astx_pkg::ASTX_OFS_CTRL);
  assign wr_baud = wr && (addr == astx_pkg::ASTX_OFS_BAUD);
  assign bif.divisor = baud_r;
  assign bif.wide    = wide_div;
  assign bif.run     = (state_r == ASTX_SEND);

  astx_baud_gen u_baud (
    .core_clk (core_clk),
    .rst      (rst),
    .bif      (bif)
  );

  // a bit ends on each tick; the frame ends after the single stop bit
  assign bit_done   = bif.tick;
  assign frame_done = bit_done && (bit_cnt_r == frame_len_r - 4'h1);
  // load when idle, or at the very end of the stop bit for back-to-back
  assign load = active && hold_full_r && ((state_r == ASTX_IDLE) || frame_done);
  assign shift_empty_status = (state_r == ASTX_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // software writable registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= astx_pkg::ASTX_CTRL_RST;
      baud_r <= astx_pkg::ASTX_BAUD_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata[7:0];
      if (wr_baud) baud_r <= wdata[15:0];
    end
  end

  // holding buffer; the ninth bit is taken with the byte write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_holding_buffer_r <= 9'h000;
      hold_full_r         <= 1'b0;
    end else if (wr_data) begin
      tx_holding_buffer_r <= {ninth_data_bit, wdata[7:0]};
      hold_full_r         <= 1'b1;
    // a write while full overwrites the queued character; software polls the flag first
    end else if (load || !transmit_enable_bit) begin
      hold_full_r         <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shifter: bit 0 is on the line; start space, data lsb first, stop mark
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r             <= ASTX_IDLE;
      tx_shift_register_r <= 10'h3ff;
      bit_cnt_r           <= 4'h0;
      frame_len_r         <= astx_pkg::ASTX_BITS_8;
    end else if (load) begin
      state_r     <= ASTX_SEND;
      bit_cnt_r   <= 4'h0;
      frame_len_r <= nine_bit_enable ? astx_pkg::ASTX_BITS_9 : astx_pkg::ASTX_BITS_8;
      // no parity generated: the ninth bit goes out as written
      tx_shift_register_r <= nine_bit_enable ? {tx_holding_buffer_r, 1'b0}
                                             : {1'b1, tx_holding_buffer_r[7:0], 1'b0};
    // abort comes before frame end so a dropped enable never lets a frame finish
    end else if (!active) begin
      state_r             <= ASTX_IDLE;
      tx_shift_register_r <= 10'h3ff;
    end else if (frame_done) begin
      state_r             <= ASTX_IDLE;
      tx_shift_register_r <= 10'h3ff;
    end else if (bit_done) begin
      bit_cnt_r           <= bit_cnt_r + 4'h1;
      tx_shift_register_r <= {1'b1, tx_shift_register_r[9:1]};
    end
  end

  // mark fills in when idle; polarity flips idle and data alike
  assign line_level = (state_r == ASTX_SEND) ? tx_shift_register_r[0] : 1'b1;
  // the line value is registered so the pin comes from a flip-flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      transmit_pin_o  <= 1'b1;
      transmit_pin_oe <= 1'b0;
    end else begin
      transmit_pin_o  <= line_level ^ output_polarity_invert;
      transmit_pin_oe <= serial_port_enable && !sync_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // empty flag: hardware only, lags a write by two cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_dly_r <= 2'b00;
      flag_r   <= 1'b0;
      transmit_enable_bit_d_r <= 1'b0;
    end else begin
      wr_dly_r <= {wr_dly_r[0], wr_data};
      transmit_enable_bit_d_r <= transmit_enable_bit;
      // held as it was (cleared if the transmitter is off) until the write has settled, then follows the buffer
      if (wr_data || wr_dly_r[0]) begin
        flag_r <= flag_r && transmit_enable_bit;
      end else begin
        flag_r <= transmit_enable_bit && !hold_full_r;
      end
    end
  end

  assign tx_irq = flag_r && buffer_empty_irq_enable;

  ////////////////////////////////////////////////////////////////////////
  // read port: data stand one cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (rst || !rd) begin
      rdata <= 32'h0000_0000;
    end else begin
      unique case (addr)
        astx_pkg::ASTX_OFS_DATA: rdata <= {23'h000000, tx_holding_buffer_r};
        astx_pkg::ASTX_OFS_CTRL: rdata <= {24'h000000, ctrl_r};
        astx_pkg::ASTX_OFS_BAUD: rdata <= {16'h0000, baud_r};
        astx_pkg::ASTX_OFS_STAT: rdata <= {29'h00000000, tx_irq, shift_empty_status, flag_r};
        default:                 rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_load;
    load;
  endsequence
  sequence s_start_out;
    ##1 (transmit_pin_o == output_polarity_invert);
  endsequence
  sequence s_bit_step;
    bit_done && !frame_done && active;
  endsequence

  property p_idle_mark;
    @(posedge core_clk) disable iff (rst)
      $past(state_r == ASTX_IDLE) && $past(output_polarity_invert) == output_polarity_invert
        |-> transmit_pin_o == !output_polarity_invert;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not at mark");

  property p_start_space;
    @(posedge core_clk) disable iff (rst) s_load ##1 (ctrl_r == $past(ctrl_r)) |-> s_start_out;
  endproperty
  a_start_space: assert property (p_start_space) else $error("start bit not space");

  property p_hold_waits;
    @(posedge core_clk) disable iff (rst)
      (state_r == ASTX_SEND) && !frame_done && hold_full_r && active |=> hold_full_r;
  endproperty
  a_hold_waits: assert property (p_hold_waits) else $error("queued char moved too early");

  property p_idle_load;
    @(posedge core_clk) disable iff (rst)
      wr_data && active && (state_r == ASTX_IDLE) && !hold_full_r |=> load ##1 (state_r == ASTX_SEND);
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle write not loaded");

  property p_flag_lag;
    @(posedge core_clk) disable iff (rst) wr_data && flag_r && transmit_enable_bit |=> flag_r;
  endproperty
  a_flag_lag: assert property (p_flag_lag) else $error("empty flag cleared too soon");

  property p_transmit_enable_bit_sets;
    @(posedge core_clk) disable iff (rst)
      transmit_enable_bit && !transmit_enable_bit_d_r && !hold_full_r && !wr_data |=> flag_r;
  endproperty
  a_transmit_enable_bit_sets: assert property (p_transmit_enable_bit_sets) else $error("enable did not set flag");

  property p_shemp;
    @(posedge core_clk) disable iff (rst) load |=> !shift_empty_status;
  endproperty
  a_shemp: assert property (p_shemp) else $error("shift empty not cleared on load");

  property p_irq_gate;
    @(posedge core_clk) disable iff (rst) tx_irq |-> flag_r && buffer_empty_irq_enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable");

  property p_oe;
    @(posedge core_clk) disable iff (rst) serial_port_enable && !sync_sel |=> transmit_pin_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not driven after port enable");

  // a frame can only close while a mark is on the line
  property p_stop_mark;
    @(posedge core_clk) disable iff (rst)
      frame_done |-> tx_shift_register_r[0];
  endproperty
  a_stop_mark: assert property (p_stop_mark) else $error("frame ended off a stop bit");

  // between two ticks the line value must not move
  property p_bit_hold;
    @(posedge core_clk) disable iff (rst)
      (state_r == ASTX_SEND) && !bit_done && active |=> $stable(line_level);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("line moved inside a bit");

  // each tick brings the next higher bit to the line
  property p_lsb_first;
    @(posedge core_clk) disable iff (rst)
      s_bit_step |=> tx_shift_register_r[0] == $past(tx_shift_register_r[1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("bits not sent lsb first");

  // marks fill in behind the data so the stop bit is always there
  property p_mark_fill;
    @(posedge core_clk) disable iff (rst)
      s_bit_step |=> tx_shift_register_r[9];
  endproperty
  a_mark_fill: assert property (p_mark_fill) else $error("shifter not filled with mark");

  // the bit counter never runs past the frame
  property p_cnt_range;
    @(posedge core_clk) disable iff (rst)
      (state_r == ASTX_SEND) |-> bit_cnt_r < frame_len_r;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("bit count beyond frame");

  // eight bit frames: start, eight data, one stop
  property p_len_eight;
    @(posedge core_clk) disable iff (rst)
      load && !nine_bit_enable |=> frame_len_r == astx_pkg::ASTX_BITS_8 && tx_shift_register_r[9];
  endproperty
  a_len_eight: assert property (p_len_eight) else $error("eight bit frame length wrong");

  // nine bit frames are one bit longer
  property p_len_nine;
    @(posedge core_clk) disable iff (rst)
      load && nine_bit_enable |=> frame_len_r == astx_pkg::ASTX_BITS_9;
  endproperty
  a_len_nine: assert property (p_len_nine) else $error("nine bit frame length wrong");

  // the ninth bit goes out as written, last of the data
  property p_ninth_msb;
    @(posedge core_clk) disable iff (rst)
      load && nine_bit_enable |=> tx_shift_register_r[9] == $past(tx_holding_buffer_r[8]);
  endproperty
  a_ninth_msb: assert property (p_ninth_msb) else $error("ninth bit not sent as msb");

  // the buffered byte moves into the shifter unchanged
  property p_load_data;
    @(posedge core_clk) disable iff (rst)
      load |=> tx_shift_register_r[8:1] == $past(tx_holding_buffer_r[7:0]);
  endproperty
  a_load_data: assert property (p_load_data) else $error("shifter data differs from buffer");

  // the start bit is on the line right after the load
  property p_load_start;
    @(posedge core_clk) disable iff (rst)
      load |=> (state_r == ASTX_SEND) && !tx_shift_register_r[0];
  endproperty
  a_load_start: assert property (p_load_start) else $error("no start bit after load");

  // leaving the enabled async setup stops the shifter
  property p_abort;
    @(posedge core_clk) disable iff (rst)
      !active |=> state_r == ASTX_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("shifter ran while disabled");

  // the pin is released for general use when the port is off
  property p_oe_off;
    @(posedge core_clk) disable iff (rst)
      !serial_port_enable || sync_sel |=> !transmit_pin_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven while port disabled");

  // once a write has settled the flag tracks the buffer
  property p_flag_follow;
    @(posedge core_clk) disable iff (rst)
      !wr_data && !wr_dly_r[0] |=> flag_r == $past(transmit_enable_bit && !hold_full_r);
  endproperty
  a_flag_follow: assert property (p_flag_follow) else $error("empty flag off buffer state");

  // no flag while the transmitter is off
  property p_flag_off;
    @(posedge core_clk) disable iff (rst)
      !transmit_enable_bit |=> !flag_r;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("empty flag set while disabled");

  // turning the transmitter off drops a queued character
  property p_hold_drop;
    @(posedge core_clk) disable iff (rst)
      !transmit_enable_bit && !wr_data |=> !hold_full_r;
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("buffer kept while disabled");

  // a queued character follows the stop bit with no idle gap
  property p_back_to_back;
    @(posedge core_clk) disable iff (rst)
      frame_done && hold_full_r && active && !wr_data
        |=> (state_r == ASTX_SEND) && !tx_shift_register_r[0] && !hold_full_r;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("queued char not sent at once");

  // the status word shows the flag, shifter state and request as they stood
  property p_stat_read;
    @(posedge core_clk) disable iff (rst)
      rd && (addr == astx_pkg::ASTX_OFS_STAT)
        |=> rdata[2:0] == {$past(tx_irq), $past(shift_empty_status), $past(flag_r)};
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read differs from state");
endmodule // astx_top

// ### testbench.sv
// self-checking bench for the serial transmitter
// assumes the register port of astx_top and a receiver model on the pin
`timescale 1ns/100ps
module testbench;
  logic        core_clk, rst, wr, rd, inv, nine, pin_o, pin_oe, tx_irq, rx_ok;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic [8:0]  rx_word;
  logic [16:0] bit_cyc;
  int          rx_cnt, rx_gap;
  int          n_fail = 0;
  int          checked = 0;
  ////////////////////////////////////////////////////////////
  astx_top dut_u (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .transmit_pin_o(pin_o), .transmit_pin_oe(pin_oe), .tx_irq(tx_irq));
  astx_rx_model rx_u (.core_clk(core_clk), .line(pin_o), .inv(inv), .nine(nine), .bit_cyc(bit_cyc),
    .rx_word(rx_word), .rx_ok(rx_ok), .rx_cnt(rx_cnt), .rx_gap(rx_gap));
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  // pin and enable are registered behind the control register
  task automatic pin_chk(input logic [1:0] e);
    repeat (2) @(posedge core_clk);
    #1 cmp({30'h0, pin_oe, pin_o}, {30'h0, e});
  endtask
  // bounded wait for the next decoded character
  task automatic rx_chk(input logic [8:0] e);
    int n;
    n = rx_cnt;
    for (int i = 0; i < 4000 && rx_cnt == n; i++) @(posedge core_clk);
    cmp(rx_cnt, n + 1);
    cmp({23'h0, rx_word}, {23'h0, e});
    cmp({31'h0, rx_ok}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////
  // watchdog: whole run needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    inv = 1'b0;
    nine = 1'b0;
    bit_cyc = 17'd4;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1 cmp({30'h0, pin_oe, pin_o}, 32'h1);
    rd_chk(astx_pkg::ASTX_OFS_STAT, 32'h2);
    rd_chk(4'h1, 32'h0);
    wr_reg(astx_pkg::ASTX_OFS_BAUD, 32'h103);
    rd_chk(astx_pkg::ASTX_OFS_BAUD, 32'h103);
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h07);
    pin_chk(2'b01);
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h05);
    pin_chk(2'b11);
    rd_chk(astx_pkg::ASTX_OFS_STAT, 32'h3);
    wr_reg(astx_pkg::ASTX_OFS_STAT, 32'h0);
    rd_chk(astx_pkg::ASTX_OFS_STAT, 32'h3);
    // back to back: second character waits in the buffer
    wr_reg(astx_pkg::ASTX_OFS_DATA, 32'ha5);
    wr_reg(astx_pkg::ASTX_OFS_DATA, 32'h3c);
    // the flag holds through the write and the cycle after it
    @(posedge core_clk);
    rd_chk(astx_pkg::ASTX_OFS_STAT, 32'h0);
    rx_chk(9'h0a5);
    rx_chk(9'h03c);
    cmp(rx_gap, 32'd40);
    repeat (6) @(posedge core_clk);
    rd_chk(astx_pkg::ASTX_OFS_STAT, 32'h3);
    // nine-bit frames with both values of the ninth bit
    nine = 1'b1;
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h35);
    wr_reg(astx_pkg::ASTX_OFS_DATA, 32'h5a);
    rx_chk(9'h15a);
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h15);
    wr_reg(astx_pkg::ASTX_OFS_DATA, 32'hff);
    rx_chk(9'h0ff);
    // wide divisor: 0x103 + 1 cycles per bit
    nine = 1'b0;
    bit_cyc = 17'd260;
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h45);
    wr_reg(astx_pkg::ASTX_OFS_DATA, 32'h96);
    rx_chk(9'h096);
    // the slow stop bit must end before the rate and the status change
    repeat (140) @(posedge core_clk);
    bit_cyc = 17'd4;
    // interrupt level follows flag and enable
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h85);
    #1 cmp({31'h0, tx_irq}, 32'h1);
    rd_chk(astx_pkg::ASTX_OFS_STAT, 32'h7);
    wr_reg(astx_pkg::ASTX_OFS_DATA, 32'h11);
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h05);
    #1 cmp({31'h0, tx_irq}, 32'h0);
    rx_chk(9'h011);
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h04);
    rd_chk(astx_pkg::ASTX_OFS_STAT, 32'h2);
    // inverted polarity last: idle becomes low
    wr_reg(astx_pkg::ASTX_OFS_CTRL, 32'h0d);
    inv <= 1'b1;
    pin_chk(2'b10);
    wr_reg(astx_pkg::ASTX_OFS_DATA, 32'h81);
    rx_chk(9'h081);
    finish_test();
  end
endmodule // testbench
